/* File: design/scid_core.sv */
// command decoder, accumulator unit and vectored interrupt dispatcher
// ---------------------------------------------------------------
// Overview of operation
// - motion numbers 2,1,4,3,30,32,31 decoded in both modes
// - parameter numbers 5,6,9,10,11,12 decoded in both modes
// - axis parameters are one set of 16 indexed by type number, not per axis; global ones are module-wide
// - flow numbers 22,21,20,23,24,27,28 only run in standalone mode
// - calculation numbers 19,33,34,35,39 decoded
// - in standalone mode every read result goes to the accumulator
// - X register holds extra data and loads from the accumulator
// - direct-mode reads leave the accumulator untouched
// - interrupt numbers 25,26,37,38 decoded
// - sources 0,1,2,3,15,21,27,28,39 each own a vector; 255 is global
// - divert only when source fired, is enabled and has a vector
// - accumulator, X register and flags saved before the handler
// - no other interrupt is taken while a handler runs
// - return restores accumulator, X, flags and resumes program
// - bank 3 global writes configure the numbered interrupt
// ---------------------------------------------------------------
`timescale 1ns/1ps
module scid_core (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_num,
	input wire logic [7:0] cmd_type,
	input wire logic [7:0] cmd_bank,
	input wire logic [31:0] cmd_value,
	input wire logic cmd_standalone,
	input wire logic prog_running,
	input wire logic [15:0] prog_pc,
	input wire logic [8:0] irq_event,
	output logic rsp_valid,
	output logic [7:0] rsp_status,
	output logic [31:0] rsp_value,
	output logic motion_valid,
	output logic [7:0] motion_op,
	output logic [7:0] motion_type,
	output logic [31:0] motion_value,
	output logic jump_valid,
	output logic [15:0] jump_addr,
	output logic wait_valid,
	output logic prog_halt,
	output logic [31:0] accum,
	output logic [31:0] xreg,
	output logic in_handler
);
	import scid_pkg::*;
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		scid_mode_type mode;
		logic gen;
		logic zf;
		logic lf;
		logic [31:0] acc;
		logic [31:0] x;
		logic sv_zf;
		logic sv_lf;
		logic [31:0] sv_acc;
		logic [31:0] sv_x;
		logic [15:0] sv_pc;
		logic [15:0] sub_pc;
		logic [15:0][31:0] axis_par;
		logic [15:0][31:0] glob;
		logic [15:0][31:0] glob_bk;
		logic [3:0][31:0] coord;
		logic irq_jump;
		logic rsp_valid;
		logic [7:0] rsp_status;
		logic [31:0] rsp_value;
		logic motion_valid;
		logic [7:0] motion_op;
		logic [7:0] motion_type;
		logic [31:0] motion_value;
		logic jump_valid;
		logic [15:0] jump_addr;
		logic wait_valid;
		logic prog_halt;
	} scid_state_type;
	scid_state_type st_q, st_d;
	logic [NUM_IRQ-1:0] en_set, en_clr, vec_wr, cfg_wr, take, ready;
	logic [NUM_IRQ-1:0][15:0] vec;
	logic [NUM_IRQ-1:0][31:0] cfg;
	// ---------------------------------------------------------------
	// interrupt slots
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NUM_IRQ; i++) begin : g_slot
		scid_irq_slot u_slot (
			.ref_clk(ref_clk),
			.reset(reset),
			.event_in(irq_event[i]),
			.en_set(en_set[i]),
			.en_clr(en_clr[i]),
			.vec_wr(vec_wr[i]),
			.vec_in(cmd_value[15:0]),
			.cfg_wr(cfg_wr[i]),
			.cfg_in(cmd_value),
			.take(take[i]),
			.ready(ready[i]),
			.vector(vec[i]),
			.cfg(cfg[i])
		);
	end
	// ---------------------------------------------------------------
	// decode and execute
	// ---------------------------------------------------------------
	logic [NUM_IRQ-1:0] hit;
	logic known, flow, rd, cond, pick;
	logic [31:0] rval, res;
	logic [3:0] idx;
	always_comb begin
		st_d = st_q;
		st_d.rsp_valid = 1'b0;
		st_d.motion_valid = 1'b0;
		st_d.jump_valid = 1'b0;
		st_d.wait_valid = 1'b0;
		st_d.prog_halt = 1'b0;
		st_d.irq_jump = 1'b0;
		en_set = '0;
		en_clr = '0;
		vec_wr = '0;
		cfg_wr = '0;
		take = '0;
		pick = 1'b0;
		rd = 1'b0;
		rval = ZERO_WORD;
		res = st_q.acc;
		idx = cmd_type[3:0];
		for (int i = 0; i < NUM_IRQ; i++) begin
			hit[i] = (cmd_type == IRQ_NUMS[i]);
		end
		case (cmd_num)
			ROTATE_RIGHT_CMD, ROTATE_LEFT_CMD, MOTOR_HALT_CMD,
			MOVE_TO_POSITION_CMD, AXIS_PARAM_WRITE_CMD, AXIS_PARAM_READ_CMD,
			GLOBAL_PARAM_WRITE_CMD, GLOBAL_PARAM_READ_CMD,
			GLOBAL_PARAM_SAVE_CMD, GLOBAL_PARAM_RECALL_CMD,
			ARITH_CONSTANT_CMD, ARITH_XREG_CMD, ACCUM_TO_AXIS_PARAM_CMD,
			ACCUM_TO_GLOBAL_PARAM_CMD, ACCUM_TO_COORDINATE_CMD,
			STORE_COORDINATE_CMD, READ_COORDINATE_CMD,
			CAPTURE_COORDINATE_CMD, IRQ_ENABLE_CMD, IRQ_DISABLE_CMD,
			IRQ_VECTOR_SET_CMD, IRQ_RETURN_CMD: begin
				known = 1'b1;
				flow = 1'b0;
			end
			JUMP_ALWAYS_CMD, JUMP_CONDITIONAL_CMD, COMPARE_CMD,
			CALL_SUBROUTINE_CMD, RETURN_SUBROUTINE_CMD, WAIT_EVENT_CMD,
			PROGRAM_END_CMD: begin
				known = 1'b1;
				flow = 1'b1;
			end
			default: begin
				known = 1'b0;
				flow = 1'b0;
			end
		endcase
		case (cmd_type[2:0])
			3'h0: cond = st_q.zf;
			3'h1: cond = ~st_q.zf;
			3'h2: cond = st_q.zf;
			3'h3: cond = ~st_q.zf;
			3'h4: cond = ~st_q.zf & ~st_q.lf;
			3'h5: cond = ~st_q.lf;
			3'h6: cond = st_q.lf;
			default: cond = st_q.lf | st_q.zf;
		endcase
		if (cmd_valid) begin
			st_d.rsp_valid = 1'b1;
			st_d.rsp_status = ST_OK;
			if (!known) begin
				st_d.rsp_status = ST_BAD_CMD;
			end else if (flow && !cmd_standalone) begin
				st_d.rsp_status = ST_WRONG_MODE;
			end else begin
				case (cmd_num)
					ROTATE_RIGHT_CMD, ROTATE_LEFT_CMD, MOTOR_HALT_CMD,
					MOVE_TO_POSITION_CMD: begin
						st_d.motion_valid = 1'b1;
						st_d.motion_op = cmd_num;
						st_d.motion_type = cmd_type;
						st_d.motion_value = cmd_value;
					end
					AXIS_PARAM_WRITE_CMD: begin
						st_d.axis_par[idx] = cmd_value;
					end
					AXIS_PARAM_READ_CMD: begin
						rd = 1'b1;
						rval = st_q.axis_par[idx];
					end
					ACCUM_TO_AXIS_PARAM_CMD: begin
						st_d.axis_par[idx] = st_q.acc;
					end
					GLOBAL_PARAM_WRITE_CMD, ACCUM_TO_GLOBAL_PARAM_CMD: begin
						res = (cmd_num == GLOBAL_PARAM_WRITE_CMD) ?
							cmd_value : st_q.acc;
						if (cmd_bank == BANK_IRQ) begin
							cfg_wr = hit;
						end else begin
							st_d.glob[idx] = res;
						end
						res = st_q.acc;
					end
					GLOBAL_PARAM_READ_CMD: begin
						rd = 1'b1;
						rval = st_q.glob[idx];
						for (int i = 0; i < NUM_IRQ; i++) begin
							if (cmd_bank == BANK_IRQ && hit[i]) begin
								rval = cfg[i];
							end
						end
					end
					GLOBAL_PARAM_SAVE_CMD: begin
						st_d.glob_bk[idx] = st_q.glob[idx];
					end
					GLOBAL_PARAM_RECALL_CMD: begin
						st_d.glob[idx] = st_q.glob_bk[idx];
					end
					STORE_COORDINATE_CMD: begin
						st_d.coord[cmd_type[1:0]] = cmd_value;
					end
					CAPTURE_COORDINATE_CMD: begin
						// actual position is axis parameter 1
						st_d.coord[cmd_type[1:0]] = st_q.axis_par[1];
					end
					READ_COORDINATE_CMD: begin
						rd = 1'b1;
						rval = st_q.coord[cmd_type[1:0]];
					end
					ACCUM_TO_COORDINATE_CMD: begin
						st_d.coord[cmd_type[1:0]] = st_q.acc;
					end
					ARITH_CONSTANT_CMD, ARITH_XREG_CMD: begin
						rval = (cmd_num == ARITH_XREG_CMD) ?
							st_q.x : cmd_value;
						case (cmd_type)
							OP_ADD: res = st_q.acc + rval;
							OP_SUB: res = st_q.acc - rval;
							OP_AND: res = st_q.acc & rval;
							OP_OR: res = st_q.acc | rval;
							OP_XOR: res = st_q.acc ^ rval;
							OP_LOAD: res = rval;
							OP_X_TO_ACC: res = st_q.x;
							default: res = st_q.acc;
						endcase
						if (cmd_num == ARITH_XREG_CMD &&
							cmd_type == OP_ACC_TO_X) begin
							st_d.x = st_q.acc;
							res = st_q.acc;
						end
						rval = ZERO_WORD;
						st_d.acc = res;
						st_d.zf = (res == ZERO_WORD);
						st_d.lf = res[31];
					end
					COMPARE_CMD: begin
						st_d.zf = (st_q.acc == cmd_value);
						st_d.lf = $signed(st_q.acc) < $signed(cmd_value);
					end
					JUMP_ALWAYS_CMD, JUMP_CONDITIONAL_CMD: begin
						st_d.jump_valid = (cmd_num == JUMP_ALWAYS_CMD) | cond;
						st_d.jump_addr = cmd_value[15:0];
					end
					CALL_SUBROUTINE_CMD: begin
						st_d.sub_pc = prog_pc;
						st_d.jump_valid = 1'b1;
						st_d.jump_addr = cmd_value[15:0];
					end
					RETURN_SUBROUTINE_CMD: begin
						st_d.jump_valid = 1'b1;
						st_d.jump_addr = st_q.sub_pc;
					end
					WAIT_EVENT_CMD: st_d.wait_valid = 1'b1;
					PROGRAM_END_CMD: st_d.prog_halt = 1'b1;
					IRQ_ENABLE_CMD, IRQ_DISABLE_CMD: begin
						if (cmd_type == IRQ_GLOBAL) begin
							st_d.gen = (cmd_num == IRQ_ENABLE_CMD);
						end else if (cmd_num == IRQ_ENABLE_CMD) begin
							en_set = hit;
						end else begin
							en_clr = hit;
						end
						if (cmd_type != IRQ_GLOBAL && hit == '0) begin
							st_d.rsp_status = ST_BAD_VALUE;
						end
					end
					IRQ_VECTOR_SET_CMD: begin
						vec_wr = hit;
						if (hit == '0) begin
							st_d.rsp_status = ST_BAD_VALUE;
						end
					end
					IRQ_RETURN_CMD: begin
						if (st_q.mode == SCID_HANDLER) begin
							st_d.mode = SCID_RUN;
							st_d.acc = st_q.sv_acc;
							st_d.x = st_q.sv_x;
							st_d.zf = st_q.sv_zf;
							st_d.lf = st_q.sv_lf;
							st_d.jump_valid = 1'b1;
							st_d.jump_addr = st_q.sv_pc;
						end
					end
					default: st_d.rsp_status = ST_BAD_CMD;
				endcase
				st_d.rsp_value = rval;
				if (rd && cmd_standalone) begin
					st_d.acc = rval;
				end
			end
		end else if (prog_running && st_q.gen &&
			st_q.mode == SCID_RUN) begin
			// dispatch only between commands so the saved pc is exact
			for (int i = NUM_IRQ - 1; i >= 0; i--) begin
				if (ready[i]) begin
					take = '0;
					take[i] = 1'b1;
					pick = 1'b1;
					st_d.jump_addr = vec[i];
				end
			end
			if (pick) begin
				st_d.mode = SCID_HANDLER;
				st_d.sv_acc = st_q.acc;
				st_d.sv_x = st_q.x;
				st_d.sv_zf = st_q.zf;
				st_d.sv_lf = st_q.lf;
				st_d.sv_pc = prog_pc;
				st_d.jump_valid = 1'b1;
				st_d.irq_jump = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign rsp_valid = st_q.rsp_valid;
	assign rsp_status = st_q.rsp_status;
	assign rsp_value = st_q.rsp_value;
	assign motion_valid = st_q.motion_valid;
	assign motion_op = st_q.motion_op;
	assign motion_type = st_q.motion_type;
	assign motion_value = st_q.motion_value;
	assign jump_valid = st_q.jump_valid;
	assign jump_addr = st_q.jump_addr;
	assign wait_valid = st_q.wait_valid;
	assign prog_halt = st_q.prog_halt;
	assign accum = st_q.acc;
	assign xreg = st_q.x;
	assign in_handler = (st_q.mode == SCID_HANDLER);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_bad_cmd;
		@(posedge ref_clk) disable iff (reset)
		(cmd_valid && !known) |=> (rsp_valid && rsp_status == ST_BAD_CMD
			&& accum == $past(accum) && xreg == $past(xreg) && !jump_valid);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd)
		else $error("bad cmd changed state");
	property p_direct_read;
		@(posedge ref_clk) disable iff (reset)
		(cmd_valid && !cmd_standalone && cmd_num == AXIS_PARAM_READ_CMD)
			|=> accum == $past(accum);
	endproperty
	a_direct_read: assert property (p_direct_read)
		else $error("direct read hit accum");
	property p_prog_read;
		@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_standalone && (cmd_num == GLOBAL_PARAM_READ_CMD
			|| cmd_num == READ_COORDINATE_CMD)) |=> accum == rsp_value;
	endproperty
	a_prog_read: assert property (p_prog_read)
		else $error("read not in accum");
	property p_motion;
		@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_num == ROTATE_LEFT_CMD) |=>
			(motion_valid && motion_op == 8'h02 && rsp_status == ST_OK);
	endproperty
	a_motion: assert property (p_motion)
		else $error("rotate left lost");
	property p_flow_direct;
		@(posedge ref_clk) disable iff (reset)
		(cmd_valid && !cmd_standalone && cmd_num == JUMP_ALWAYS_CMD) |=>
			(!jump_valid && rsp_status == ST_WRONG_MODE);
	endproperty
	a_flow_direct: assert property (p_flow_direct)
		else $error("flow in direct");
	property p_xload;
		@(posedge ref_clk) disable iff (reset)
		(cmd_valid && cmd_num == ARITH_XREG_CMD && cmd_type == OP_ACC_TO_X)
			|=> xreg == $past(accum);
	endproperty
	a_xload: assert property (p_xload)
		else $error("x load failed");
	property p_save;
		@(posedge ref_clk) disable iff (reset)
		$rose(in_handler) |-> (st_q.sv_acc == $past(accum) &&
			st_q.sv_x == $past(xreg) && jump_valid && st_q.irq_jump);
	endproperty
	a_save: assert property (p_save)
		else $error("context not saved");
	property p_divert;
		@(posedge ref_clk) disable iff (reset)
		st_q.irq_jump |-> $past(st_q.gen && (ready != '0) && !cmd_valid);
	endproperty
	a_divert: assert property (p_divert)
		else $error("divert without cause");
	property p_no_nest;
		@(posedge ref_clk) disable iff (reset)
		(in_handler && !(cmd_valid && cmd_num == IRQ_RETURN_CMD)) |=>
			(in_handler && !st_q.irq_jump);
	endproperty
	a_no_nest: assert property (p_no_nest)
		else $error("nested handler");
	property p_restore;
		@(posedge ref_clk) disable iff (reset)
		(in_handler && cmd_valid && cmd_num == IRQ_RETURN_CMD) |=>
			(!in_handler && accum == $past(st_q.sv_acc) && jump_valid
			&& jump_addr == $past(st_q.sv_pc));
	endproperty
	a_restore: assert property (p_restore)
		else $error("return not restored");
endmodule

/* File: include/scid_pkg.sv */
// package: command numbers, status codes, interrupt map and state types
package scid_pkg;
	// ---------------------------------------------------------------
	// command numbers
	// ---------------------------------------------------------------
	localparam logic [7:0] ROTATE_RIGHT_CMD = 8'h01;
	localparam logic [7:0] ROTATE_LEFT_CMD = 8'h02;
	localparam logic [7:0] MOTOR_HALT_CMD = 8'h03;
	localparam logic [7:0] MOVE_TO_POSITION_CMD = 8'h04;
	localparam logic [7:0] AXIS_PARAM_WRITE_CMD = 8'h05;
	localparam logic [7:0] AXIS_PARAM_READ_CMD = 8'h06;
	localparam logic [7:0] GLOBAL_PARAM_WRITE_CMD = 8'h09;
	localparam logic [7:0] GLOBAL_PARAM_READ_CMD = 8'h0A;
	localparam logic [7:0] GLOBAL_PARAM_SAVE_CMD = 8'h0B;
	localparam logic [7:0] GLOBAL_PARAM_RECALL_CMD = 8'h0C;
	localparam logic [7:0] ARITH_CONSTANT_CMD = 8'h13;
	localparam logic [7:0] COMPARE_CMD = 8'h14;
	localparam logic [7:0] JUMP_CONDITIONAL_CMD = 8'h15;
	localparam logic [7:0] JUMP_ALWAYS_CMD = 8'h16;
	localparam logic [7:0] CALL_SUBROUTINE_CMD = 8'h17;
	localparam logic [7:0] RETURN_SUBROUTINE_CMD = 8'h18;
	localparam logic [7:0] IRQ_ENABLE_CMD = 8'h19;
	localparam logic [7:0] IRQ_DISABLE_CMD = 8'h1A;
	localparam logic [7:0] WAIT_EVENT_CMD = 8'h1B;
	localparam logic [7:0] PROGRAM_END_CMD = 8'h1C;
	localparam logic [7:0] STORE_COORDINATE_CMD = 8'h1E;
	localparam logic [7:0] READ_COORDINATE_CMD = 8'h1F;
	localparam logic [7:0] CAPTURE_COORDINATE_CMD = 8'h20;
	localparam logic [7:0] ARITH_XREG_CMD = 8'h21;
	localparam logic [7:0] ACCUM_TO_AXIS_PARAM_CMD = 8'h22;
	localparam logic [7:0] ACCUM_TO_GLOBAL_PARAM_CMD = 8'h23;
	localparam logic [7:0] IRQ_VECTOR_SET_CMD = 8'h25;
	localparam logic [7:0] IRQ_RETURN_CMD = 8'h26;
	localparam logic [7:0] ACCUM_TO_COORDINATE_CMD = 8'h27;
	// ---------------------------------------------------------------
	// status codes, banks, arithmetic codes and interrupt map
	// ---------------------------------------------------------------
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;
	localparam logic [7:0] ST_WRONG_MODE = 8'h06;
	localparam logic [7:0] BANK_USER = 8'h00;
	localparam logic [7:0] BANK_IRQ = 8'h03;
	localparam logic [7:0] OP_ADD = 8'h00;
	localparam logic [7:0] OP_SUB = 8'h01;
	localparam logic [7:0] OP_AND = 8'h02;
	localparam logic [7:0] OP_OR = 8'h03;
	localparam logic [7:0] OP_XOR = 8'h04;
	localparam logic [7:0] OP_LOAD = 8'h05;
	localparam logic [7:0] OP_ACC_TO_X = 8'h05;
	localparam logic [7:0] OP_X_TO_ACC = 8'h06;
	localparam int NUM_IRQ = 9;
	localparam logic [7:0] IRQ_GLOBAL = 8'hFF;
	localparam logic [NUM_IRQ-1:0][7:0] IRQ_NUMS = {8'h27, 8'h1C, 8'h1B,
		8'h15, 8'h0F, 8'h03, 8'h02, 8'h01, 8'h00};
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [15:0] ZERO_ADDR = 16'h0000;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic {SCID_RUN = 1'b0, SCID_HANDLER = 1'b1} scid_mode_type;
endpackage

/* File: design/scid_irq_slot.sv */
// one interrupt source: pending latch, enable, vector and configuration
`timescale 1ns/1ps
module scid_irq_slot (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic event_in,
	input wire logic en_set,
	input wire logic en_clr,
	input wire logic vec_wr,
	input wire logic [15:0] vec_in,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_in,
	input wire logic take,
	output logic ready,
	output logic [15:0] vector,
	output logic [31:0] cfg
);
	import scid_pkg::*;
	typedef struct packed {
		logic pend;
		logic en;
		logic vld;
		logic [15:0] vec;
		logic [31:0] cfg;
	} scid_slot_type;
	scid_slot_type st_q, st_d;
	always_comb begin
		st_d = st_q;
		// an event in the cycle of the take re-arms the latch
		st_d.pend = event_in | (st_q.pend & ~take);
		if (en_set) begin
			st_d.en = 1'b1;
		end else if (en_clr) begin
			st_d.en = 1'b0;
		end
		if (vec_wr) begin
			st_d.vld = 1'b1;
			st_d.vec = vec_in;
		end
		if (cfg_wr) begin
			st_d.cfg = cfg_in;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign ready = st_q.pend & st_q.en & st_q.vld;
	assign vector = st_q.vec;
	assign cfg = st_q.cfg;
endmodule

/* File: tb/scid_host.sv */
// host model: sends one command at a time and keeps the reply
`timescale 1ns/1ps
module scid_host (
	input wire logic ref_clk,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_status,
	input wire logic [31:0] rsp_value,
	output logic cmd_valid,
	output logic [7:0] cmd_num,
	output logic [7:0] cmd_type,
	output logic [7:0] cmd_bank,
	output logic [31:0] cmd_value,
	output logic cmd_standalone
);
	logic got_rsp;
	logic [7:0] status;
	logic [31:0] value;
	initial begin
		cmd_valid = 1'b0;
		cmd_num = 8'h00;
		cmd_type = 8'h00;
		cmd_bank = 8'h00;
		cmd_value = 32'h0;
		cmd_standalone = 1'b0;
	end
	// ---------------------------------------------------------------
	// command transfer
	// ---------------------------------------------------------------
	// released fields are inverted so a stale command never looks valid
	task automatic send(input logic [7:0] num, input logic [7:0] typ,
		input logic [7:0] bank, input logic [31:0] val, input logic sa);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_num <= num;
		cmd_type <= typ;
		cmd_bank <= bank;
		cmd_value <= val;
		cmd_standalone <= sa;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		cmd_num <= ~num;
		cmd_type <= ~typ;
		cmd_bank <= ~bank;
		cmd_value <= ~val;
		#1;
		got_rsp = rsp_valid;
		status = rsp_status;
		value = rsp_value;
	endtask
endmodule

/* File: tb/script_command_interrupt_dispatch_test.sv */
// testbench: command decode, accumulator and interrupt dispatch
`timescale 1ns/1ps
module script_command_interrupt_dispatch_test;
	import scid_pkg::*;
	logic ref_clk, reset, prog_running, cmd_valid, cmd_standalone;
	logic [7:0] cmd_num, cmd_type, cmd_bank, rsp_status, motion_op;
	logic [7:0] motion_type;
	logic [31:0] cmd_value, rsp_value, motion_value, accum, xreg;
	logic [15:0] prog_pc, jump_addr;
	logic [8:0] irq_event;
	logic rsp_valid, motion_valid, jump_valid, wait_valid, prog_halt;
	logic in_handler;
	int error_cnt = 0;
	int tests_run = 0;
	scid_host host (.ref_clk(ref_clk), .rsp_valid(rsp_valid),
		.rsp_status(rsp_status), .rsp_value(rsp_value),
		.cmd_valid(cmd_valid), .cmd_num(cmd_num), .cmd_type(cmd_type),
		.cmd_bank(cmd_bank), .cmd_value(cmd_value),
		.cmd_standalone(cmd_standalone));
	scid_core dut (.ref_clk(ref_clk), .reset(reset),
		.cmd_valid(cmd_valid), .cmd_num(cmd_num), .cmd_type(cmd_type),
		.cmd_bank(cmd_bank), .cmd_value(cmd_value),
		.cmd_standalone(cmd_standalone), .prog_running(prog_running),
		.prog_pc(prog_pc), .irq_event(irq_event),
		.rsp_valid(rsp_valid), .rsp_status(rsp_status),
		.rsp_value(rsp_value), .motion_valid(motion_valid),
		.motion_op(motion_op), .motion_type(motion_type),
		.motion_value(motion_value), .jump_valid(jump_valid),
		.jump_addr(jump_addr), .wait_valid(wait_valid),
		.prog_halt(prog_halt), .accum(accum), .xreg(xreg),
		.in_handler(in_handler));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// every command leaves an idle edge behind it, where dispatch can act
	task automatic cmd(input logic [7:0] num, input logic [7:0] typ = 8'h00,
		input logic [31:0] val = 32'h0, input logic sa = 1'b1,
		input logic [7:0] st = ST_OK, input logic [7:0] bank = 8'h00);
		host.send(num, typ, bank, val, sa);
		check("reply", 32'(host.got_rsp), 32'h1);
		check("status", 32'(host.status), 32'(st));
	endtask
	task automatic poll(output logic hit);
		hit = 1'b0;
		for (int i = 0; i < 4 && !hit; i++) begin
			#1;
			hit = (jump_valid === 1'b1);
			if (!hit)
				@(posedge ref_clk);
		end
	endtask
	task automatic want_jump(input logic [15:0] addr);
		logic hit;
		poll(hit);
		if (!hit) begin
			error_cnt++;
			$display("BAD jump_valid expected 1 seen 0");
			finish_test();
		end
		check("jump_addr", 32'(jump_addr), 32'(addr));
		check("in_handler", 32'(in_handler), 32'h1);
	endtask
	task automatic no_jump();
		logic hit;
		poll(hit);
		check("no_jump", 32'(hit), 32'h0);
	endtask
	task automatic pulse(input logic [8:0] ev);
		@(posedge ref_clk);
		prog_running <= 1'b1;
		irq_event <= ev;
		@(posedge ref_clk);
		irq_event <= 9'h000;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		@(posedge ref_clk);
		#1;
		check("rsp_valid", 32'(rsp_valid), 32'h0);
		check("accum", accum, 32'h0);
		check("in_handler", 32'(in_handler), 32'h0);
		$display("reset test done");
	endtask
	task automatic t_motion();
		logic [7:0] nums [4] = '{ROTATE_RIGHT_CMD, ROTATE_LEFT_CMD,
			MOTOR_HALT_CMD, MOVE_TO_POSITION_CMD};
		for (int m = 0; m < 2; m++) begin
			foreach (nums[i]) begin
				cmd(nums[i], 8'h01, 32'h100 + i, m[0]);
				check("mvalid", 32'(motion_valid), 32'h1);
				check("mop", 32'(motion_op), 32'(nums[i]));
				check("mval", motion_value, 32'h100 + i);
				check("mtype", 32'(motion_type), 32'h01);
			end
		end
		$display("motion test done");
	endtask
	task automatic t_params();
		cmd(AXIS_PARAM_WRITE_CMD, 8'h02, 32'hA5, 1'b0);
		cmd(GLOBAL_PARAM_WRITE_CMD, 8'h02, 32'h5A, 1'b0);
		cmd(AXIS_PARAM_READ_CMD, 8'h02, 32'h0, 1'b0);
		check("gap", host.value, 32'hA5);
		check("accum", accum, 32'h0);
		cmd(GLOBAL_PARAM_SAVE_CMD, 8'h02, 32'h0, 1'b0);
		cmd(GLOBAL_PARAM_WRITE_CMD, 8'h02, 32'h77, 1'b0);
		cmd(GLOBAL_PARAM_RECALL_CMD, 8'h02, 32'h0, 1'b0);
		cmd(GLOBAL_PARAM_READ_CMD, 8'h02);
		check("ggp", accum, 32'h5A);
		cmd(AXIS_PARAM_READ_CMD, 8'h02);
		check("accum", accum, 32'hA5);
		cmd(STORE_COORDINATE_CMD, 8'h01, 32'hC0DE, 1'b0);
		cmd(CAPTURE_COORDINATE_CMD, 8'h02, 32'h0, 1'b0);
		cmd(READ_COORDINATE_CMD, 8'h01, 32'h0, 1'b0);
		check("gco", host.value, 32'hC0DE);
		check("accum", accum, 32'hA5);
		$display("parameter test done");
	endtask
	task automatic t_arith_constant_cmd();
		logic [31:0] res [5] = '{32'h4B, 32'hFFFFFFD3, 32'h0C, 32'h3F,
			32'h33};
		for (int i = 0; i < 5; i++) begin
			cmd(ARITH_CONSTANT_CMD, OP_LOAD, 32'h0F);
			cmd(ARITH_CONSTANT_CMD, 8'(i), 32'h3C);
			check("arith_constant_cmd", accum, res[i]);
		end
		cmd(ARITH_XREG_CMD, OP_ACC_TO_X);
		check("xreg", xreg, 32'h33);
		cmd(ARITH_CONSTANT_CMD, OP_LOAD, 32'h09);
		cmd(ACCUM_TO_AXIS_PARAM_CMD, 8'h03);
		cmd(ACCUM_TO_GLOBAL_PARAM_CMD, 8'h04);
		cmd(ACCUM_TO_COORDINATE_CMD, 8'h02);
		cmd(ARITH_XREG_CMD, OP_X_TO_ACC);
		check("accum", accum, 32'h33);
		cmd(AXIS_PARAM_READ_CMD, 8'h03, 32'h0, 1'b0);
		check("aap", host.value, 32'h09);
		cmd(GLOBAL_PARAM_READ_CMD, 8'h04, 32'h0, 1'b0);
		check("agp", host.value, 32'h09);
		cmd(READ_COORDINATE_CMD, 8'h02, 32'h0, 1'b0);
		check("aco", host.value, 32'h09);
		$display("calculation test done");
	endtask
	task automatic t_flow();
		logic [7:0] fl [7] = '{COMPARE_CMD, JUMP_CONDITIONAL_CMD,
			JUMP_ALWAYS_CMD, CALL_SUBROUTINE_CMD, RETURN_SUBROUTINE_CMD,
			WAIT_EVENT_CMD, PROGRAM_END_CMD};
		foreach (fl[i]) begin
			cmd(fl[i], 8'h00, 32'h10, 1'b0, ST_WRONG_MODE);
			check("jv", 32'(jump_valid), 32'h0);
		end
		cmd(JUMP_ALWAYS_CMD, 8'h00, 32'h123);
		check("ja", 32'({jump_valid, jump_addr}), 32'h1_0123);
		cmd(COMPARE_CMD, 8'h00, 32'h33);
		cmd(JUMP_CONDITIONAL_CMD, 8'h03, 32'h200);
		check("jc_ne", 32'(jump_valid), 32'h0);
		cmd(JUMP_CONDITIONAL_CMD, 8'h02, 32'h201);
		check("jc_eq", 32'({jump_valid, jump_addr}), 32'h1_0201);
		// equal compare: greater and less fail, the or-equal forms jump
		for (int c = 4; c < 8; c++) begin
			cmd(JUMP_CONDITIONAL_CMD, 8'(c), 32'h210);
			check("jc", 32'(jump_valid), 32'(c % 2));
		end
		@(posedge ref_clk);
		prog_pc <= 16'h0050;
		cmd(CALL_SUBROUTINE_CMD, 8'h00, 32'h300);
		check("call_subroutine_cmd", 32'({jump_valid, jump_addr}), 32'h1_0300);
		cmd(RETURN_SUBROUTINE_CMD);
		check("return_subroutine_cmd", 32'({jump_valid, jump_addr}), 32'h1_0050);
		cmd(WAIT_EVENT_CMD);
		check("wait", 32'(wait_valid), 32'h1);
		cmd(PROGRAM_END_CMD);
		check("halt", 32'(prog_halt), 32'h1);
		$display("flow test done");
	endtask
	task automatic t_bad();
		logic [7:0] bad [6] = '{8'h00, 8'h07, 8'h0D, 8'h1D, 8'h24, 8'hFF};
		foreach (bad[i]) begin
			cmd(bad[i], 8'h00, 32'h1, 1'b1, ST_BAD_CMD);
			check("accum", accum, 32'h33);
			check("mvalid", 32'(motion_valid), 32'h0);
		end
		cmd(IRQ_ENABLE_CMD, 8'h05, 32'h0, 1'b1, ST_BAD_VALUE);
		$display("invalid command test done");
	endtask
	task automatic t_irq();
		cmd(ARITH_CONSTANT_CMD, OP_LOAD, 32'h22);
		cmd(ARITH_XREG_CMD, OP_ACC_TO_X);
		cmd(ARITH_CONSTANT_CMD, OP_LOAD, 32'h11);
		cmd(COMPARE_CMD, 8'h00, 32'h11);
		@(posedge ref_clk);
		prog_pc <= 16'h0077;
		cmd(IRQ_VECTOR_SET_CMD, 8'h03, 32'h40);
		cmd(GLOBAL_PARAM_WRITE_CMD, 8'h03, 32'h99, 1'b1, ST_OK,
			BANK_IRQ);
		cmd(GLOBAL_PARAM_READ_CMD, 8'h03, 32'h0, 1'b0, ST_OK,
			BANK_IRQ);
		check("irq_cfg", host.value, 32'h99);
		cmd(IRQ_ENABLE_CMD, 8'h03);
		cmd(IRQ_ENABLE_CMD, 8'h01);
		pulse(9'h00A);
		no_jump();
		cmd(IRQ_ENABLE_CMD, IRQ_GLOBAL);
		want_jump(16'h0040);
		// the handler clobbers accumulator, X and flags on purpose
		cmd(ARITH_CONSTANT_CMD, OP_LOAD, 32'h55);
		cmd(ARITH_XREG_CMD, OP_ACC_TO_X);
		pulse(9'h008);
		no_jump();
		cmd(IRQ_DISABLE_CMD, 8'h03);
		cmd(IRQ_RETURN_CMD);
		check("irq_return_cmd", 32'({jump_valid, jump_addr}), 32'h1_0077);
		check("accum", accum, 32'h11);
		check("xreg", xreg, 32'h22);
		check("in_handler", 32'(in_handler), 32'h0);
		@(posedge ref_clk);
		no_jump();
		cmd(JUMP_CONDITIONAL_CMD, 8'h00, 32'h5);
		check("flags", 32'({jump_valid, jump_addr}), 32'h1_0005);
		$display("interrupt test done");
	endtask
	task automatic t_irq_vector_set_cmd();
		logic [7:0] nums [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'h15,
			8'h1B, 8'h1C, 8'h27};
		// events still pending from the last test must not fire here
		cmd(IRQ_DISABLE_CMD, IRQ_GLOBAL);
		foreach (nums[i]) begin
			cmd(IRQ_VECTOR_SET_CMD, nums[i], 32'h100 + i);
			cmd(IRQ_ENABLE_CMD, nums[i]);
			cmd(IRQ_DISABLE_CMD, nums[i]);
		end
		cmd(IRQ_ENABLE_CMD, 8'h27);
		cmd(IRQ_ENABLE_CMD, IRQ_GLOBAL);
		pulse(9'h100);
		want_jump(16'h0108);
		cmd(IRQ_RETURN_CMD);
		cmd(IRQ_DISABLE_CMD, IRQ_GLOBAL);
		cmd(IRQ_VECTOR_SET_CMD, 8'h04, 32'h0, 1'b1, ST_BAD_VALUE);
		$display("vector test done");
	endtask
	initial begin
		reset = 1'b1;
		prog_running = 1'b0;
		prog_pc = 16'h0000;
		irq_event = 9'h000;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_motion();
		t_params();
		t_arith_constant_cmd();
		t_flow();
		t_bad();
		t_irq();
		t_irq_vector_set_cmd();
		finish_test();
	end
endmodule
